// File: inc/wakeup_line_stop_entry_unit_defines.svh
`ifndef WAKEUP_LINE_STOP_ENTRY_UNIT_DEFINES_SVH
`define WAKEUP_LINE_STOP_ENTRY_UNIT_DEFINES_SVH

// register offsets
`define WU_CLOCK_FLAG_ADDR 8'hF0
`define WU_TOP_CTRL_ADDR 8'hF1
`define WU_CHANNEL_ADDR 8'hF2
`define WU_CONTROL_ADDR 8'hF9
`define WU_MASK_UPPER_ADDR 8'hFA
`define WU_MASK_LOWER_ADDR 8'hFB
`define WU_POLARITY_UPPER_ADDR 8'hFC
`define WU_POLARITY_LOWER_ADDR 8'hFD
`define WU_PENDING_UPPER_ADDR 8'hFE
`define WU_PENDING_LOWER_ADDR 8'hFF

// wakeup_control fields
`define WU_CTRL_MODE_BIT 0
`define WU_CTRL_SOURCE_BIT 1
`define WU_CTRL_STOP_BIT 2

// top-level control fields
`define WU_TOP_EDGE_BIT 0
`define WU_TOP_ENABLE_BIT 1
`define WU_TOP_GLOBAL_BIT 2
`define WU_TOP_UNMASK_BIT 3
`define WU_TOP_PENDING_BIT 4

// clock flag and channel fields
`define WU_FLAG_EXIT_BIT 0
`define WU_FLAG_STOPPED_BIT 1
`define WU_CHAN_PENDING_BIT 0
`define WU_CHAN_MASK_BIT 1

// reset values
`define WU_BYTE_RESET 8'h00
`define WU_LINES_RESET 16'h0000

// oscillator restart delay in cycles
`define WU_OSC_RESTART_CYCLES 16

`endif

// File: inc/wakeup_line_stop_entry_unit_pkg.sv
package wakeup_line_stop_entry_unit_pkg;

  // gray codes along run -> arm -> stopped -> restart
  typedef enum logic [2:0] {
    RUN_ST = 3'h0,
    ARM_ONE_ST = 3'h1,
    ARM_ZERO_ST = 3'h3,
    STOPPED_ST = 3'h2,
    RESTART_ST = 3'h6
  } stop_state_t;

endpackage

// File: src/wakeup_line_stop_entry_unit.sv
// How it works
// - correct sequence with top pin high: no stop, stop bit one, exit flag zero
// - blocked attempt stays blocked when pin falls; software must clear and rearm
// - top pin rising edge during arming aborts; stop bit and exit flag zero
// - wake-up line event during arming aborts; pending bit stays set
// - exit flag sticky after real exit; zero after a filtered entry attempt
// - unmasked wake-up line event ends stop after oscillator restart delay
// - top pin rising edge also ends stop, a seventeenth wake-up source
// - pending bits edge set; cleared bit waits for a fresh edge
// - selected top edge sets top pending; request if unmaskable or both enables
// - top unmaskable bit set by software, cleared only by reset
// - each top request needs a fresh edge of the selected polarity; a held level does nothing
// - top pin low at third write of correct sequence allows stop entry
// - shared channel pending set only on rising edge of combined line signal
// - clearing one pending bit with another left set re-arms channel pending
// - wake-up mode select bit stays readable for service routines
// - control register eight bits, reset zero: stop bit2, source bit1, mode bit0
// - entry needs pin low, wake mode, no unmasked pending, one line unmasked
// - any other register write between arming writes rejects the sequence
// - source select gives channel request, wake mode gives wake-up event
// - polarity zero selects falling edge, one selects rising edge
`include "wakeup_line_stop_entry_unit_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module wakeup_line_stop_entry_unit #(
  parameter int LINES = 16,
  parameter int OSC_RESTART_CYCLES = `WU_OSC_RESTART_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [LINES-1:0] wake_lines,
  input wire logic top_pin,
  input wire logic dedicated_ext_irq_pin,
  input wire logic irq_dma_ack,
  input wire logic ext_reg_write,
  output logic shared_irq_channel,
  output logic top_irq_request,
  output logic wake_event,
  output logic stop_mode
);

  wakeup_line_stop_entry_unit_pkg::stop_state_t state_reg;
  wakeup_line_stop_entry_unit_pkg::stop_state_t state_next;

  logic [7:0] wakeup_control_reg;
  logic [LINES-1:0] mask_reg;
  logic [LINES-1:0] polarity_reg;
  logic [LINES-1:0] pending_reg;
  logic [LINES-1:0] pending_next;
  logic [LINES-1:0] sync1_reg;
  logic [LINES-1:0] sync2_reg;
  logic [LINES-1:0] line_prev_reg;
  logic [LINES-1:0] line_edge;
  logic [LINES-1:0] polarity_write;
  logic top_prev_reg;
  logic top_rise;
  logic top_edge;
  logic top_edge_select_reg;
  logic top_level_enable_reg;
  logic global_irq_enable_reg;
  logic top_level_unmaskable_reg;
  logic top_level_pending_reg;
  logic channel_pending_bit_reg;
  logic channel_mask_bit_reg;
  logic combined_prev_reg;
  logic combined;
  logic stop_exit_flag_reg;
  logic spoiled_reg;
  logic [15:0] restart_cnt_reg;
  logic unmasked_pending;
  logic line_wake;
  logic line_set_any;
  logic abort_now;
  logic ctrl_write;
  logic foreign_write;
  logic stop_written;
  logic entry_ok;
  logic [7:0] rd_mux;

  wire logic wakeup_mode_select = wakeup_control_reg[`WU_CTRL_MODE_BIT];
  wire logic shared_channel_source_select = wakeup_control_reg[`WU_CTRL_SOURCE_BIT];

  assign ctrl_write = wr_en && (addr == `WU_CONTROL_ADDR);
  assign stop_written = wr_data[`WU_CTRL_STOP_BIT];
  // writes to any other register, ours or the cpu's, spoil the arming sequence
  assign foreign_write = (wr_en && !ctrl_write) || ext_reg_write || irq_dma_ack;

  // ---- wake-up lines: sync, edge detect, pending ----
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_reg <= `WU_LINES_RESET;
      sync2_reg <= `WU_LINES_RESET;
      line_prev_reg <= `WU_LINES_RESET;
    end else begin
      sync1_reg <= wake_lines;
      sync2_reg <= sync1_reg;
      line_prev_reg <= sync2_reg;
    end
  end

  // an edge landing while its polarity byte is rewritten is dropped on purpose
  assign polarity_write[LINES-1:8] = {(LINES-8){wr_en && (addr == `WU_POLARITY_UPPER_ADDR)}};
  assign polarity_write[7:0] = {8{wr_en && (addr == `WU_POLARITY_LOWER_ADDR)}};
  assign line_edge = ((polarity_reg & sync2_reg & ~line_prev_reg)
                     | (~polarity_reg & ~sync2_reg & line_prev_reg)) & ~polarity_write;
  assign line_set_any = |line_edge;

  always_comb begin
    pending_next = pending_reg;
    if (wr_en && (addr == `WU_PENDING_UPPER_ADDR)) begin
      pending_next[LINES-1:8] = wr_data[LINES-9:0];
    end
    if (wr_en && (addr == `WU_PENDING_LOWER_ADDR)) begin
      pending_next[7:0] = wr_data;
    end
    // set beats clear; a held level never sets again after a clear
    pending_next = pending_next | line_edge;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pending_reg <= `WU_LINES_RESET;
    end else begin
      pending_reg <= pending_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mask_reg <= `WU_LINES_RESET;
      polarity_reg <= `WU_LINES_RESET;
    end else if (wr_en) begin
      if (addr == `WU_MASK_UPPER_ADDR) begin
        mask_reg[LINES-1:8] <= wr_data[LINES-9:0];
      end
      if (addr == `WU_MASK_LOWER_ADDR) begin
        mask_reg[7:0] <= wr_data;
      end
      if (addr == `WU_POLARITY_UPPER_ADDR) begin
        polarity_reg[LINES-1:8] <= wr_data[LINES-9:0];
      end
      if (addr == `WU_POLARITY_LOWER_ADDR) begin
        polarity_reg[7:0] <= wr_data;
      end
    end
  end

  assign unmasked_pending = |(pending_reg & mask_reg);
  assign line_wake = unmasked_pending && wakeup_mode_select;

  // ---- shared channel ----
  assign combined = shared_channel_source_select ? unmasked_pending
                                                 : dedicated_ext_irq_pin;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      combined_prev_reg <= 1'b0;
      channel_pending_bit_reg <= 1'b0;
      channel_mask_bit_reg <= 1'b0;
    end else begin
      // a pending write briefly drops the merged line, so a bit still set re-arms it
      combined_prev_reg <= combined && !(shared_channel_source_select && wr_en
                           && (addr == `WU_PENDING_UPPER_ADDR
                               || addr == `WU_PENDING_LOWER_ADDR));
      if (wr_en && (addr == `WU_CHANNEL_ADDR)) begin
        channel_mask_bit_reg <= wr_data[`WU_CHAN_MASK_BIT];
      end
      // only a rising edge of the merged signal registers a request
      if (combined && !combined_prev_reg) begin
        channel_pending_bit_reg <= 1'b1;
      end else if (wr_en && (addr == `WU_CHANNEL_ADDR)) begin
        channel_pending_bit_reg <= wr_data[`WU_CHAN_PENDING_BIT];
      end
    end
  end

  // ---- top-level pin ----
  assign top_rise = top_pin && !top_prev_reg;
  assign top_edge = top_edge_select_reg ? top_rise : (!top_pin && top_prev_reg);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      top_prev_reg <= 1'b0;
      top_edge_select_reg <= 1'b0;
      top_level_enable_reg <= 1'b0;
      global_irq_enable_reg <= 1'b0;
      top_level_unmaskable_reg <= 1'b0;
      top_level_pending_reg <= 1'b0;
    end else begin
      top_prev_reg <= top_pin;
      if (wr_en && (addr == `WU_TOP_CTRL_ADDR)) begin
        top_edge_select_reg <= wr_data[`WU_TOP_EDGE_BIT];
        top_level_enable_reg <= wr_data[`WU_TOP_ENABLE_BIT];
        global_irq_enable_reg <= wr_data[`WU_TOP_GLOBAL_BIT];
        if (wr_data[`WU_TOP_UNMASK_BIT]) begin
          top_level_unmaskable_reg <= 1'b1;
        end
      end
      if (top_edge) begin
        top_level_pending_reg <= 1'b1;
      end else if (wr_en && (addr == `WU_TOP_CTRL_ADDR)) begin
        top_level_pending_reg <= wr_data[`WU_TOP_PENDING_BIT];
      end
    end
  end

  // ---- arming sequence and stop state ----
  // pending rise or top rise inside the sequence means the cpu takes an interrupt
  assign abort_now = foreign_write || line_set_any || top_rise;
  assign entry_ok = wakeup_mode_select && !unmasked_pending && (|mask_reg);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      wakeup_line_stop_entry_unit_pkg::RUN_ST: begin
        if (ctrl_write && stop_written) begin
          state_next = wakeup_line_stop_entry_unit_pkg::ARM_ONE_ST;
        end
      end
      wakeup_line_stop_entry_unit_pkg::ARM_ONE_ST: begin
        if (ctrl_write) begin
          state_next = stop_written ? wakeup_line_stop_entry_unit_pkg::ARM_ONE_ST
                                    : wakeup_line_stop_entry_unit_pkg::ARM_ZERO_ST;
        end
      end
      wakeup_line_stop_entry_unit_pkg::ARM_ZERO_ST: begin
        if (ctrl_write) begin
          if (!stop_written) begin
            state_next = wakeup_line_stop_entry_unit_pkg::RUN_ST;
          end else if (!spoiled_reg && !abort_now && !top_pin && entry_ok) begin
            state_next = wakeup_line_stop_entry_unit_pkg::STOPPED_ST;
          end else begin
            state_next = wakeup_line_stop_entry_unit_pkg::RUN_ST;
          end
        end
      end
      wakeup_line_stop_entry_unit_pkg::STOPPED_ST: begin
        if (line_wake || top_rise) begin
          state_next = wakeup_line_stop_entry_unit_pkg::RESTART_ST;
        end
      end
      wakeup_line_stop_entry_unit_pkg::RESTART_ST: begin
        if (restart_cnt_reg == 16'(OSC_RESTART_CYCLES - 1)) begin
          state_next = wakeup_line_stop_entry_unit_pkg::RUN_ST;
        end
      end
      default: begin
        state_next = wakeup_line_stop_entry_unit_pkg::RUN_ST;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= wakeup_line_stop_entry_unit_pkg::RUN_ST;
    end else begin
      state_reg <= state_next;
    end
  end

  // the spoiled mark lives until the sequence is finished or broken
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      spoiled_reg <= 1'b0;
    end else if (state_next == wakeup_line_stop_entry_unit_pkg::ARM_ONE_ST
                 || state_next == wakeup_line_stop_entry_unit_pkg::ARM_ZERO_ST) begin
      if (state_reg == wakeup_line_stop_entry_unit_pkg::RUN_ST) begin
        spoiled_reg <= 1'b0;
      end else if (abort_now) begin
        spoiled_reg <= 1'b1;
      end
    end else begin
      spoiled_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      restart_cnt_reg <= 16'h0000;
    end else if (state_reg == wakeup_line_stop_entry_unit_pkg::RESTART_ST) begin
      restart_cnt_reg <= restart_cnt_reg + 16'h0001;
    end else begin
      restart_cnt_reg <= 16'h0000;
    end
  end

  // control register: mode and source plain, stop bit shaped by the sequence
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wakeup_control_reg <= `WU_BYTE_RESET;
    end else begin
      if (ctrl_write) begin
        wakeup_control_reg[1:0] <= wr_data[1:0];
      end
      if (ctrl_write && state_reg == wakeup_line_stop_entry_unit_pkg::ARM_ZERO_ST
          && stop_written) begin
        // blocked by a high pin leaves the bit set with no stop behind it
        wakeup_control_reg[`WU_CTRL_STOP_BIT] <= !spoiled_reg && !abort_now
                                                 && (top_pin || entry_ok);
      end else if (ctrl_write && state_reg != wakeup_line_stop_entry_unit_pkg::STOPPED_ST) begin
        wakeup_control_reg[`WU_CTRL_STOP_BIT] <= stop_written;
      end else if (state_reg == wakeup_line_stop_entry_unit_pkg::STOPPED_ST
                   && line_wake && !top_rise) begin
        wakeup_control_reg[`WU_CTRL_STOP_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stop_exit_flag_reg <= 1'b0;
    end else if (state_reg == wakeup_line_stop_entry_unit_pkg::STOPPED_ST
                 && (line_wake || top_rise)) begin
      stop_exit_flag_reg <= 1'b1;
    end else if (ctrl_write && state_reg == wakeup_line_stop_entry_unit_pkg::ARM_ZERO_ST
                 && stop_written
                 && state_next != wakeup_line_stop_entry_unit_pkg::STOPPED_ST) begin
      stop_exit_flag_reg <= 1'b0;
    end else if (wr_en && (addr == `WU_CLOCK_FLAG_ADDR)) begin
      stop_exit_flag_reg <= wr_data[`WU_FLAG_EXIT_BIT];
    end
  end

  // ---- register reads ----
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      `WU_CLOCK_FLAG_ADDR: begin
        rd_mux[`WU_FLAG_EXIT_BIT] = stop_exit_flag_reg;
        rd_mux[`WU_FLAG_STOPPED_BIT] = stop_mode;
      end
      `WU_TOP_CTRL_ADDR: begin
        rd_mux[`WU_TOP_EDGE_BIT] = top_edge_select_reg;
        rd_mux[`WU_TOP_ENABLE_BIT] = top_level_enable_reg;
        rd_mux[`WU_TOP_GLOBAL_BIT] = global_irq_enable_reg;
        rd_mux[`WU_TOP_UNMASK_BIT] = top_level_unmaskable_reg;
        rd_mux[`WU_TOP_PENDING_BIT] = top_level_pending_reg;
      end
      `WU_CHANNEL_ADDR: begin
        rd_mux[`WU_CHAN_PENDING_BIT] = channel_pending_bit_reg;
        rd_mux[`WU_CHAN_MASK_BIT] = channel_mask_bit_reg;
      end
      `WU_CONTROL_ADDR: rd_mux = {5'h00, wakeup_control_reg[2:0]};
      `WU_MASK_UPPER_ADDR: rd_mux = mask_reg[LINES-1:8];
      `WU_MASK_LOWER_ADDR: rd_mux = mask_reg[7:0];
      `WU_POLARITY_UPPER_ADDR: rd_mux = polarity_reg[LINES-1:8];
      `WU_POLARITY_LOWER_ADDR: rd_mux = polarity_reg[7:0];
      `WU_PENDING_UPPER_ADDR: rd_mux = pending_reg[LINES-1:8];
      `WU_PENDING_LOWER_ADDR: rd_mux = pending_reg[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  // ---- registered outputs ----
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
      shared_irq_channel <= 1'b0;
      top_irq_request <= 1'b0;
      wake_event <= 1'b0;
      stop_mode <= 1'b0;
    end else begin
      rd_data <= rd_en ? rd_mux : 8'h00;
      shared_irq_channel <= channel_pending_bit_reg && channel_mask_bit_reg;
      top_irq_request <= top_level_pending_reg && (top_level_unmaskable_reg
                         || (top_level_enable_reg && global_irq_enable_reg));
      wake_event <= line_wake;
      // clock stays held until the oscillator restart delay is over
      stop_mode <= (state_next == wakeup_line_stop_entry_unit_pkg::STOPPED_ST)
                   || (state_next == wakeup_line_stop_entry_unit_pkg::RESTART_ST);
    end
  end

endmodule

`default_nettype wire

// File: bench/wakeup_line_stop_entry_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_line_stop_entry_unit_sva #(
  parameter int OSC_RESTART_CYCLES = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic top_pin,
  input wire logic irq_dma_ack,
  input wire logic ext_reg_write,
  input wire logic wake_event,
  input wire logic stop_mode
);
  // detection plus restart delay, with margin for the edge pipeline
  localparam int EXIT_MAX = OSC_RESTART_CYCLES + 6;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  a_rd_unmapped: assert property ($past(rd_en) && $past(addr) < 8'hF0 |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_entry_by_arm: assert property ($rose(stop_mode) |->
    $past(wr_en) && $past(addr) == 8'hF9 && $past(wr_data[2]))
    else $error("stop entered without third arming write");
  a_entry_pin_low: assert property ($rose(stop_mode) |-> !$past(top_pin))
    else $error("stop entered with top pin high");
  a_entry_no_spoil: assert property ($rose(stop_mode) |->
    !$past(irq_dma_ack) && !$past(ext_reg_write))
    else $error("stop entered despite intervening write");
  a_stop_min_len: assert property ($rose(stop_mode) |-> stop_mode [*2])
    else $error("stop mode too short");
  a_line_exit_bound: assert property (stop_mode && wake_event |-> ##[1:EXIT_MAX] !stop_mode)
    else $error("wake-up line did not end stop");
  a_top_exit_bound: assert property (stop_mode && $rose(top_pin) |-> ##[1:EXIT_MAX] !stop_mode)
    else $error("top pin edge did not end stop");
endmodule
bind wakeup_line_stop_entry_unit wakeup_line_stop_entry_unit_sva #(
  .OSC_RESTART_CYCLES(OSC_RESTART_CYCLES)
) u_sva (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .addr(addr),
  .wr_data(wr_data),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rd_data(rd_data),
  .top_pin(top_pin),
  .irq_dma_ack(irq_dma_ack),
  .ext_reg_write(ext_reg_write),
  .wake_event(wake_event),
  .stop_mode(stop_mode)
);
`default_nettype wire

// File: bench/wake_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: sixteen wake-up pins and the top pin, lagging LAG cycles (1 to 8)
module wake_pin_model #(
  parameter int LAG = 1
) (
  input wire logic ref_clk,
  input wire logic [15:0] line_req,
  input wire logic top_req,
  output logic [15:0] wake_lines,
  output logic top_pin
);
  logic [16:0] pipe_reg [0:7] = '{default: 17'h00000};
  // pins only move right after an edge, never glitch: a glitch would set pending
  always @(posedge ref_clk) begin
    pipe_reg[0] <= {top_req, line_req};
    for (int i = 1; i < 8; i++) begin
      pipe_reg[i] <= pipe_reg[i-1];
    end
  end
  assign {top_pin, wake_lines} = pipe_reg[LAG-1];
endmodule
`default_nettype wire

// File: bench/wakeup_line_stop_entry_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_line_stop_entry_unit_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic [15:0] wake_lines;
  logic [15:0] line_req = 16'h0000;
  logic top_pin;
  logic top_req = 1'b0;
  logic ext_irq = 1'b0;
  logic irq_dma_ack = 1'b0;
  logic ext_reg_write = 1'b0;
  logic shared_irq_channel, top_irq_request, wake_event, stop_mode;
  int err_total = 0;
  int num_checks = 0;
  wakeup_line_stop_entry_unit #(.OSC_RESTART_CYCLES(2)) u_wakeup_line_stop_entry_unit (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .wake_lines(wake_lines),
    .top_pin(top_pin), .dedicated_ext_irq_pin(ext_irq), .irq_dma_ack(irq_dma_ack),
    .ext_reg_write(ext_reg_write), .shared_irq_channel(shared_irq_channel),
    .top_irq_request(top_irq_request), .wake_event(wake_event), .stop_mode(stop_mode));
  wake_pin_model #(.LAG(1)) u_wake_pin_model (.ref_clk(ref_clk), .line_req(line_req),
    .top_req(top_req), .wake_lines(wake_lines), .top_pin(top_pin));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ends just after an edge so outputs read here have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask
  task automatic set_lines(input logic [15:0] v);
    @(posedge ref_clk);
    line_req <= v;
    cyc(8);
  endtask
  task automatic set_top(input logic v);
    @(posedge ref_clk);
    top_req <= v;
    cyc(4);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (stop_mode !== 1'b0 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h00, stop_mode}, 8'h00);
  endtask
  task automatic prep();
    wr(8'hFD, 8'h01);
    wr(8'hFB, 8'h01);
    wr(8'hFF, 8'h00);
    wr(8'hFE, 8'h00);
    wr(8'hF0, 8'h00);
    wr(8'hF9, 8'h01);
  endtask
  task automatic arm();
    wr(8'hF9, 8'h05);
    wr(8'hF9, 8'h01);
    wr(8'hF9, 8'h05);
    cyc(2);
  endtask
  task automatic t_reset();
    rd_chk(8'hF9, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'hF0, 8'h00);
    wr(8'hF9, 8'hFF);
    rd_chk(8'hF9, 8'h07);
    wr(8'hF9, 8'h00);
  endtask
  task automatic t_lines();
    wr(8'hFD, 8'h01);
    wr(8'hFB, 8'h03);
    wr(8'hF9, 8'h02);
    wr(8'hF2, 8'h02);
    set_lines(16'h0001);
    rd_chk(8'hFF, 8'h01);
    chk({7'h00, shared_irq_channel}, 8'h01);
    wr(8'hFF, 8'h00);
    cyc(4);
    rd_chk(8'hFF, 8'h00);
    wr(8'hF2, 8'h02);
    set_lines(16'h0003);
    rd_chk(8'hFF, 8'h00);
    set_lines(16'h0001);
    rd_chk(8'hFF, 8'h02);
    set_lines(16'h0003);
    wr(8'hF2, 8'h02);
    cyc(3);
    chk({7'h00, shared_irq_channel}, 8'h00);
    wr(8'hFF, 8'h01);
    cyc(4);
    chk({7'h00, shared_irq_channel}, 8'h01);
    set_lines(16'h0000);
    wr(8'hF2, 8'h00);
    wr(8'hFE, 8'h00);
    wr(8'hF2, 8'h00);
    wr(8'hFF, 8'h00);
    cyc(4);
    chk({7'h00, shared_irq_channel}, 8'h00);
  endtask
  task automatic t_line_exit();
    prep();
    arm();
    chk({7'h00, stop_mode}, 8'h01);
    rd_chk(8'hF0, 8'h02);
    set_lines(16'h0001);
    wait_run();
    rd_chk(8'hF0, 8'h01);
    rd_chk(8'hF9, 8'h01);
    rd_chk(8'hFF, 8'h01);
    wr(8'hFF, 8'h00);
    wr(8'hF0, 8'h00);
    rd_chk(8'hF0, 8'h00);
    set_lines(16'h0000);
  endtask
  task automatic t_top_exit();
    prep();
    arm();
    chk({7'h00, stop_mode}, 8'h01);
    set_top(1'b1);
    wait_run();
    rd_chk(8'hF9, 8'h05);
    rd_chk(8'hF0, 8'h01);
    set_top(1'b0);
  endtask
  task automatic t_top_high();
    set_top(1'b1);
    prep();
    arm();
    chk({7'h00, stop_mode}, 8'h00);
    rd_chk(8'hF9, 8'h05);
    rd_chk(8'hF0, 8'h00);
    set_top(1'b0);
    cyc(4);
    chk({7'h00, stop_mode}, 8'h00);
    set_top(1'b1);
    prep();
    wr(8'hF9, 8'h05);
    wr(8'hF9, 8'h01);
    set_top(1'b0);
    wr(8'hF9, 8'h05);
    cyc(2);
    chk({7'h00, stop_mode}, 8'h01);
    set_lines(16'h0001);
    wait_run();
    set_lines(16'h0000);
  endtask
  task automatic t_spoil();
    for (int k = 0; k < 5; k++) begin
      prep();
      wr(8'hF9, 8'h05);
      @(posedge ref_clk);
      case (k)
        0: ext_reg_write <= 1'b1;
        1: irq_dma_ack <= 1'b1;
        2: top_req <= 1'b1;
        3: line_req <= 16'h0001;
        default: ;
      endcase
      @(posedge ref_clk);
      ext_reg_write <= 1'b0;
      irq_dma_ack <= 1'b0;
      if (k == 4) begin
        wr(8'hFA, 8'h00);
      end
      cyc(6);
      wr(8'hF9, 8'h01);
      wr(8'hF9, 8'h05);
      cyc(2);
      chk({7'h00, stop_mode}, 8'h00);
      rd_chk(8'hF9, 8'h01);
      rd_chk(8'hF0, 8'h00);
      rd_chk(8'hFF, (k == 3) ? 8'h01 : 8'h00);
      top_req <= 1'b0;
      line_req <= 16'h0000;
      cyc(6);
    end
  endtask
  task automatic t_top_req();
    wr(8'hF1, 8'h07);
    set_top(1'b1);
    chk({7'h00, top_irq_request}, 8'h01);
    rd_chk(8'hF1, 8'h17);
    wr(8'hF1, 8'h03);
    cyc(3);
    chk({7'h00, top_irq_request}, 8'h00);
    wr(8'hF1, 8'h0B);
    cyc(3);
    chk({7'h00, top_irq_request}, 8'h00);
    set_top(1'b0);
    set_top(1'b1);
    chk({7'h00, top_irq_request}, 8'h01);
    wr(8'hF1, 8'h00);
    rd_chk(8'hF1, 8'h08);
  endtask
  initial begin
    #300000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(1);
    t_reset();
    t_lines();
    t_line_exit();
    t_top_exit();
    t_top_high();
    t_spoil();
    t_top_req();
    summarize();
  end
endmodule
`default_nettype wire
